// ---- design/rpm_pin_mux.sv ----
// remappable pin mux with key-guarded write lock and shadow monitoring
//
// Strobed register access and the placing of the registers were decided locally.
`timescale 1ns/100ps
module rpm_pin_mux #(
  parameter int VARIANT_44 = 1                        // 1: 44-pin, 0: 28-pin
) (
  input  wire logic        CLK_SYS_IN,                // 40 MHz system clock
  input  wire logic        RST_N_IN,                  // async active-low reset
  input  wire logic [7:0]  ADDR_IN,                   // register word address
  input  wire logic [15:0] WDATA_IN,                  // write data
  input  wire logic        WR_IN,                     // write strobe
  input  wire logic        RD_IN,                     // read strobe
  output logic      [15:0] RDATA_OUT,                 // read data, cycle after
  input  wire logic        FUSE_SINGLE_IN,            // single session fuse, 1 unprogrammed
  input  wire logic [31:0] FUNC_OUT_IN,               // peripheral outputs by code
  input  wire logic [31:0] PORT_OUT_IN,               // port values per pin
  input  wire logic [31:0] PIN_IN,                    // pin input levels
  output logic      [31:0] PIN_OUT,                   // pin drive values
  output logic      [31:0] PIN_OE_OUT,                // remapped output owns pin
  output logic      [22:0] PERIPH_IN_OUT,             // peripheral input levels
  output logic             MISMATCH_RST_OUT,          // configuration mismatch reset
  output logic             LOCK_OUT                   // current map write lock
);
  localparam logic [31:0] PRESENT = (VARIANT_44 != 0) ? rpm_pkg::PINS_44 : rpm_pkg::PINS_28;

  // mapping registers and their shadows
  logic [15:0] in_regs   [rpm_pkg::NUM_IN_REGS];     // input selector pairs
  logic [15:0] out_regs  [rpm_pkg::NUM_OUT_REGS];    // output selector pairs
  logic [15:0] in_shadow [rpm_pkg::NUM_IN_REGS];
  logic [15:0] out_shadow[rpm_pkg::NUM_OUT_REGS];
  logic        map_write_lock;                       // lock bit
  logic        locked_once;                          // lock set this session
  logic        mismatch;                             // sticky mismatch flag
  rpm_pkg::rpm_key_e key_state;
  rpm_pkg::rpm_key_e next_key_state;

  // address decode
  wire logic       hit_osc  = (ADDR_IN == rpm_pkg::ADDR_OSC_CTRL);
  wire logic       hit_stat = (ADDR_IN == rpm_pkg::ADDR_STATUS);
  wire logic [7:0] in_off   = ADDR_IN - rpm_pkg::ADDR_IN_BASE;
  wire logic [7:0] out_off  = ADDR_IN - rpm_pkg::ADDR_OUT_BASE;
  wire logic       hit_in   = (ADDR_IN >= rpm_pkg::ADDR_IN_BASE) &&
                              (in_off < 8'(rpm_pkg::NUM_IN_REGS));
  wire logic       hit_out  = (ADDR_IN >= rpm_pkg::ADDR_OUT_BASE) &&
                              (out_off < 8'(rpm_pkg::NUM_OUT_REGS));
  // mapping writes only pass while unlocked; locked writes are dropped
  wire logic       map_wr   = WR_IN && !map_write_lock;
  wire logic       osc_wr   = WR_IN && hit_osc;
  // lock change needs both keys and the fuse not pinning it set
  wire logic       lock_req = osc_wr && (key_state == rpm_pkg::RPM_KEY2);
  wire logic       new_lock = WDATA_IN[rpm_pkg::LOCK_BIT];
  wire logic       fuse_pin = FUSE_SINGLE_IN && locked_once;
  wire logic       lock_chg = lock_req && !(fuse_pin && !new_lock);

  // key recogniser: any other write breaks the sequence
  always_comb begin
    next_key_state = key_state;
    if (WR_IN) begin
      if (osc_wr && WDATA_IN[7:0] == rpm_pkg::KEY_ONE && key_state != rpm_pkg::RPM_KEY1) begin
        next_key_state = rpm_pkg::RPM_KEY1;
      end else if (osc_wr && WDATA_IN[7:0] == rpm_pkg::KEY_TWO &&
                   key_state == rpm_pkg::RPM_KEY1) begin
        next_key_state = rpm_pkg::RPM_KEY2;
      end else begin
        next_key_state = rpm_pkg::RPM_IDLE;
      end
    end
  end

  // key state register
  always_ff @(posedge CLK_SYS_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      key_state <= rpm_pkg::RPM_IDLE;
    end else begin
      key_state <= next_key_state;
    end
  end

  // lock bit holds until the next accepted change
  always_ff @(posedge CLK_SYS_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      map_write_lock <= rpm_pkg::LOCK_RST;
      locked_once    <= 1'b0;
    end else if (lock_chg) begin
      map_write_lock <= new_lock;
      locked_once    <= locked_once | new_lock;
    end
  end

  // mapping registers, two fields per word
  genvar gi;
  generate
    for (gi = 0; gi < rpm_pkg::NUM_IN_REGS; gi++) begin : g_in
      always_ff @(posedge CLK_SYS_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
          in_regs[gi]   <= {3'h0, rpm_pkg::IN_SEL_RST, 3'h0, rpm_pkg::IN_SEL_RST};
          in_shadow[gi] <= {3'h0, rpm_pkg::IN_SEL_RST, 3'h0, rpm_pkg::IN_SEL_RST};
        end else if (map_wr && hit_in && in_off == 8'(gi)) begin
          in_regs[gi]   <= WDATA_IN & 16'h1f1f;
          in_shadow[gi] <= WDATA_IN & 16'h1f1f;
        end
      end
    end
    for (gi = 0; gi < rpm_pkg::NUM_OUT_REGS; gi++) begin : g_out
      always_ff @(posedge CLK_SYS_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
          out_regs[gi]   <= {3'h0, rpm_pkg::OUT_SEL_RST, 3'h0, rpm_pkg::OUT_SEL_RST};
          out_shadow[gi] <= {3'h0, rpm_pkg::OUT_SEL_RST, 3'h0, rpm_pkg::OUT_SEL_RST};
        end else if (map_wr && hit_out && out_off == 8'(gi)) begin
          out_regs[gi]   <= WDATA_IN & 16'h1f1f;
          out_shadow[gi] <= WDATA_IN & 16'h1f1f;
        end
      end
    end
  endgenerate

  // continuous shadow compare
  logic any_diff;
  always_comb begin
    any_diff = 1'b0;
    for (int i = 0; i < rpm_pkg::NUM_IN_REGS; i++) begin
      any_diff = any_diff | (in_regs[i] != in_shadow[i]);
    end
    for (int i = 0; i < rpm_pkg::NUM_OUT_REGS; i++) begin
      any_diff = any_diff | (out_regs[i] != out_shadow[i]);
    end
  end

  // mismatch reset request, held until device reset
  always_ff @(posedge CLK_SYS_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      mismatch <= 1'b0;
    end else if (any_diff) begin
      mismatch <= 1'b1;
    end
  end
  assign MISMATCH_RST_OUT = mismatch;
  assign LOCK_OUT         = map_write_lock;

  // per-pin output muxes; a function may appear on many pins
  // one selector per pin blocks contention; remap beats port value
  generate
    for (gi = 0; gi < rpm_pkg::NUM_PINS; gi++) begin : g_pin
      wire logic [4:0] psel = out_regs[gi/2][(gi%2)*rpm_pkg::HI_FIELD +: rpm_pkg::SEL_W];
      rpm_out_sel u_sel (
        .sel_in      (psel),
        .funcs_in    (FUNC_OUT_IN),
        .port_out_in (PORT_OUT_IN[gi]),
        .present_in  (PRESENT[gi]),
        .pin_out     (PIN_OUT[gi]),
        .remap_out   (PIN_OE_OUT[gi])
      );
    end
    // input muxes: pin 31 or absent pins tie the input low
    for (gi = 0; gi < rpm_pkg::NUM_INPUTS; gi++) begin : g_inp
      wire logic [4:0] isel = in_regs[gi/2][(gi%2)*rpm_pkg::HI_FIELD +: rpm_pkg::SEL_W];
      assign PERIPH_IN_OUT[gi] = (isel != rpm_pkg::IN_SEL_RST) && PRESENT[isel] && PIN_IN[isel];
    end
  endgenerate

  // read mux and registered read data
  logic [15:0] rd_word;
  always_comb begin
    rd_word = 16'h0000;
    if (hit_osc) begin
      rd_word[rpm_pkg::LOCK_BIT] = map_write_lock;
    end else if (hit_stat) begin
      rd_word = {14'h0000, FUSE_SINGLE_IN, mismatch};
    end else if (hit_in) begin
      rd_word = in_regs[in_off[3:0]];
    end else if (hit_out) begin
      rd_word = out_regs[out_off[3:0]];
    end
  end
  always_ff @(posedge CLK_SYS_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      RDATA_OUT <= 16'h0000;
    end else if (RD_IN) begin
      RDATA_OUT <= rd_word;
    end else begin
      RDATA_OUT <= 16'h0000;
    end
  end

  // checks
  property p_locked_write;
    @(posedge CLK_SYS_IN) disable iff (!RST_N_IN)
      (WR_IN && map_write_lock && hit_out) |=>
        out_regs[$past(out_off[3:0])] == $past(out_regs[out_off[3:0]]);
  endproperty
  a_locked_write: assert property (p_locked_write) else $error("locked write changed map");
  property p_lock_needs_key;
    @(posedge CLK_SYS_IN) disable iff (!RST_N_IN)
      $changed(map_write_lock) |-> $past(key_state) == rpm_pkg::RPM_KEY2;
  endproperty
  a_lock_needs_key: assert property (p_lock_needs_key) else $error("lock changed without key");
  property p_fuse_hold;
    @(posedge CLK_SYS_IN) disable iff (!RST_N_IN)
      (FUSE_SINGLE_IN && locked_once && map_write_lock) |=> map_write_lock;
  endproperty
  a_fuse_hold: assert property (p_fuse_hold) else $error("fuse lock cleared");
  property p_lock_hold;
    @(posedge CLK_SYS_IN) disable iff (!RST_N_IN)
      !lock_req |=> $stable(map_write_lock);
  endproperty
  a_lock_hold: assert property (p_lock_hold) else $error("lock moved by itself");
  property p_null_off;
    @(posedge CLK_SYS_IN) disable iff (!RST_N_IN)
      (out_regs[0][4:0] == rpm_pkg::OUT_NULL) |-> !PIN_OE_OUT[0];
  endproperty
  a_null_off: assert property (p_null_off) else $error("null pin driven");
  property p_cmp_one;
    @(posedge CLK_SYS_IN) disable iff (!RST_N_IN)
      (out_regs[0][4:0] == rpm_pkg::OUT_CMP_ONE) |-> PIN_OUT[0] == FUNC_OUT_IN[1];
  endproperty
  a_cmp_one: assert property (p_cmp_one) else $error("pin 0 not comparator one");
  property p_unused_code;
    @(posedge CLK_SYS_IN) disable iff (!RST_N_IN)
      (out_regs[0][4:0] == 5'h1f) |-> PIN_OUT[0] == PORT_OUT_IN[0];
  endproperty
  a_unused_code: assert property (p_unused_code) else $error("unused code drove pin");
  property p_key_break;
    @(posedge CLK_SYS_IN) disable iff (!RST_N_IN)
      (WR_IN && !hit_osc) |=> key_state == rpm_pkg::RPM_IDLE;
  endproperty
  a_key_break: assert property (p_key_break) else $error("key survived other write");
  property p_mismatch;
    @(posedge CLK_SYS_IN) disable iff (!RST_N_IN)
      any_diff |=> MISMATCH_RST_OUT;
  endproperty
  a_mismatch: assert property (p_mismatch) else $error("mismatch not raised");
  // reset leaves outputs null, inputs tied low and the lock open
  property p_rst_vals;
    @(posedge CLK_SYS_IN)
      !RST_N_IN |=> (out_regs[0][4:0] == rpm_pkg::OUT_SEL_RST) &&
                    (in_regs[0][12:8] == rpm_pkg::IN_SEL_RST) && !map_write_lock;
  endproperty
  a_rst_vals: assert property (p_rst_vals) else $error("bad reset");
  // mapping writes land while unlocked, masked to the two fields
  property p_map_write;
    @(posedge CLK_SYS_IN) disable iff (!RST_N_IN)
      (WR_IN && !map_write_lock && hit_out) |=>
        out_regs[$past(out_off[3:0])] == ($past(WDATA_IN) & 16'h1f1f);
  endproperty
  a_map_write: assert property (p_map_write) else $error("open write lost");
  // an accepted lock write takes the written bit
  property p_lock_take;
    @(posedge CLK_SYS_IN) disable iff (!RST_N_IN)
      lock_chg |=> map_write_lock == $past(new_lock);
  endproperty
  a_lock_take: assert property (p_lock_take) else $error("lock write not taken");
  // with the fuse intact a set lock refuses to clear
  property p_fuse_refuse;
    @(posedge CLK_SYS_IN) disable iff (!RST_N_IN)
      (lock_req && fuse_pin && !new_lock) |=> $stable(map_write_lock);
  endproperty
  a_fuse_refuse: assert property (p_fuse_refuse) else $error("fuse bypassed");
  // the second key byte arms the lock write
  property p_key_arm;
    @(posedge CLK_SYS_IN) disable iff (!RST_N_IN)
      (osc_wr && key_state == rpm_pkg::RPM_KEY1 && WDATA_IN[7:0] == rpm_pkg::KEY_TWO) |=>
        key_state == rpm_pkg::RPM_KEY2;
  endproperty
  a_key_arm: assert property (p_key_arm) else $error("key not armed");
  // a tied-off input reads low
  property p_in_tied;
    @(posedge CLK_SYS_IN) disable iff (!RST_N_IN)
      (in_regs[0][4:0] == rpm_pkg::IN_SEL_RST) |-> !PERIPH_IN_OUT[0];
  endproperty
  a_in_tied: assert property (p_in_tied) else $error("tied input not low");
  // input zero follows the pin that its field names
  property p_in_route;
    @(posedge CLK_SYS_IN) disable iff (!RST_N_IN)
      (in_regs[0][4:0] == 5'h02) |-> PERIPH_IN_OUT[0] == PIN_IN[2];
  endproperty
  a_in_route: assert property (p_in_route) else $error("input not routed");
  // first compare channel reaches pin zero
  property p_oc_first;
    @(posedge CLK_SYS_IN) disable iff (!RST_N_IN)
      (out_regs[0][4:0] == rpm_pkg::OUT_OC_FIRST) |->
        PIN_OE_OUT[0] && PIN_OUT[0] == FUNC_OUT_IN[rpm_pkg::OUT_OC_FIRST];
  endproperty
  a_oc_first: assert property (p_oc_first) else $error("compare one not on pin");
  // pin twelve never exists, whatever its field holds
  property p_absent_pin;
    @(posedge CLK_SYS_IN) disable iff (!RST_N_IN)
      (out_regs[6][4:0] != rpm_pkg::OUT_NULL) |-> !PIN_OE_OUT[12];
  endproperty
  a_absent_pin: assert property (p_absent_pin) else $error("absent pin driven");
  c_unlock: cover property (@(posedge CLK_SYS_IN) disable iff (!RST_N_IN) lock_chg && !new_lock);
  c_lock:   cover property (@(posedge CLK_SYS_IN) disable iff (!RST_N_IN) lock_chg && new_lock);
  c_remap:  cover property (@(posedge CLK_SYS_IN) disable iff (!RST_N_IN) PIN_OE_OUT[0]);
  c_fuse:   cover property (@(posedge CLK_SYS_IN) disable iff (!RST_N_IN) lock_req && fuse_pin);
  c_fanout: cover property (@(posedge CLK_SYS_IN) disable iff (!RST_N_IN) &PIN_OE_OUT[1:0]);
endmodule : rpm_pin_mux

// ---- inc/rpm_pkg.sv ----
// package: register map, codes and reset values for the remappable pin mux
package rpm_pkg;
  localparam int NUM_PINS      = 32;        // selector encodings cover 32 pins
  localparam int SEL_W         = 5;         // selector field width
  localparam int NUM_INPUTS    = 23;        // peripheral inputs with a selector
  localparam int NUM_OUT_FUNCS = 32;        // output function codes
  localparam int ADDR_W        = 8;
  localparam int DATA_W        = 16;
  // register word addresses
  localparam logic [7:0] ADDR_OSC_CTRL = 8'h00;   // oscillator control reg
  localparam logic [7:0] ADDR_STATUS   = 8'h01;   // mismatch status
  localparam logic [7:0] ADDR_IN_BASE  = 8'h10;   // 12 input select regs
  localparam logic [7:0] ADDR_OUT_BASE = 8'h40;   // 16 output select regs
  localparam int NUM_IN_REGS  = 12;
  localparam int NUM_OUT_REGS = 16;
  // field positions
  localparam int LOCK_BIT  = 6;
  localparam int FUSE_BIT  = 4;
  localparam int LO_FIELD  = 0;
  localparam int HI_FIELD  = 8;
  // key bytes
  localparam logic [7:0] KEY_ONE = 8'h46;
  localparam logic [7:0] KEY_TWO = 8'h57;
  // reset values
  localparam logic [SEL_W-1:0] IN_SEL_RST  = 5'h1f;
  localparam logic [SEL_W-1:0] OUT_SEL_RST = 5'h00;
  localparam logic             LOCK_RST    = 1'b0;
  // output function codes
  localparam logic [SEL_W-1:0] OUT_NULL       = 5'h00;
  localparam logic [SEL_W-1:0] OUT_CMP_ONE    = 5'h01;
  localparam logic [SEL_W-1:0] OUT_SPI_TWO_SS = 5'h0c;
  localparam logic [SEL_W-1:0] OUT_OC_FIRST   = 5'h12;
  localparam logic [SEL_W-1:0] OUT_OC_LAST    = 5'h16;
  localparam logic [SEL_W-1:0] OUT_CT_PULSE   = 5'h1d;
  localparam logic [SEL_W-1:0] OUT_CMP_THREE  = 5'h1e;
  // implemented pin masks per variant (bit n set = pin n exists)
  localparam logic [31:0] PINS_28 = 32'h0000efff & ~32'h00001000;
  localparam logic [31:0] PINS_44 = 32'h03ffefff;
  // key recogniser states
  typedef enum logic [1:0] {RPM_IDLE, RPM_KEY1, RPM_KEY2} rpm_key_e;
endpackage : rpm_pkg

// ---- design/rpm_out_sel.sv ----
// one remappable pin: selects a peripheral output by code and overrides port
`timescale 1ns/100ps
module rpm_out_sel (
  input  wire logic [4:0]  sel_in,       // output selector code
  input  wire logic [31:0] funcs_in,     // peripheral outputs, indexed by code
  input  wire logic        port_out_in,  // general purpose port value
  input  wire logic        present_in,   // pin exists on this variant
  output logic             pin_out,      // resolved pin value
  output logic             remap_out     // pin owned by a remapped output
);
  // codes with a function behind them
  wire logic code_used;
  assign code_used = (sel_in != rpm_pkg::OUT_NULL) &&
                     ((sel_in <= rpm_pkg::OUT_SPI_TWO_SS) ||
                      ((sel_in >= rpm_pkg::OUT_OC_FIRST) && (sel_in <= rpm_pkg::OUT_OC_LAST)) ||
                      (sel_in == rpm_pkg::OUT_CT_PULSE) || (sel_in == rpm_pkg::OUT_CMP_THREE));
  // one selector per pin means only one function can ever own it
  assign remap_out = present_in && code_used;
  assign pin_out   = remap_out ? funcs_in[sel_in] : port_out_in;
endmodule : rpm_out_sel

// ---- tb/rpm_periph_model.sv ----
// far side model: peripheral outputs, port values and pin levels
`timescale 1ns/100ps
module rpm_periph_model (
  input  wire logic        clk_in,        // system clock
  output logic      [31:0] func_out,      // peripheral outputs by code
  output logic      [31:0] port_out,      // port latch values per pin
  output logic      [31:0] pin_level_out  // levels seen on the pins
);
  // start values differ per bit so a wrong selection shows up, then
  // everything moves each cycle so a stale pass-through cannot match by luck
  initial begin
    func_out      = 32'h5a3c96e1;
    port_out      = 32'hc3a50ff0;
    pin_level_out = 32'h00000004;
    forever @(posedge clk_in) begin
      func_out      <= ~func_out;
      port_out      <= {port_out[30:0], port_out[31]};
      pin_level_out <= ~pin_level_out;
    end
  end
endmodule : rpm_periph_model

// ---- tb/rpm_pin_mux_tb.sv ----
// self-checking bench for the remappable pin mux
`timescale 1ns/100ps
module rpm_pin_mux_tb;
  logic        clk = 1'b0, rst_n = 1'b0;   // clock and active-low reset
  logic [7:0]  addr = 8'h00;               // register address
  logic [15:0] wdata = 16'h0000, rdata;    // bus data
  logic        wr = 1'b0, rd = 1'b0;       // strobes
  logic        fuse = 1'b0, lock, mism;    // fuse level, lock, mismatch
  logic [31:0] func, port, pin_lvl, pin_o, oe, oe28;
  logic [22:0] pin_in_sel;                 // peripheral input levels
  logic [15:0] v;                          // read value
  int          n_fail = 0, checks_done = 0;
  rpm_pin_mux #(.VARIANT_44(1)) DUT (.CLK_SYS_IN(clk), .RST_N_IN(rst_n), .ADDR_IN(addr),
    .WDATA_IN(wdata), .WR_IN(wr), .RD_IN(rd), .RDATA_OUT(rdata), .FUSE_SINGLE_IN(fuse),
    .FUNC_OUT_IN(func), .PORT_OUT_IN(port), .PIN_IN(pin_lvl), .PIN_OUT(pin_o),
    .PIN_OE_OUT(oe), .PERIPH_IN_OUT(pin_in_sel), .MISMATCH_RST_OUT(mism), .LOCK_OUT(lock));
  // 28-pin variant on the same bus, only its pin ownership is watched
  rpm_pin_mux #(.VARIANT_44(0)) DUT28 (.CLK_SYS_IN(clk), .RST_N_IN(rst_n), .ADDR_IN(addr),
    .WDATA_IN(wdata), .WR_IN(wr), .RD_IN(rd), .RDATA_OUT(), .FUSE_SINGLE_IN(fuse),
    .FUNC_OUT_IN(func), .PORT_OUT_IN(port), .PIN_IN(pin_lvl), .PIN_OUT(),
    .PIN_OE_OUT(oe28), .PERIPH_IN_OUT(), .MISMATCH_RST_OUT(), .LOCK_OUT());
  rpm_periph_model far (.clk_in(clk), .func_out(func), .port_out(port), .pin_level_out(pin_lvl));
  // 40 MHz clock
  initial begin
    forever #12.5 clk = ~clk;
  end
  // compare seen against expected and count
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  // one write cycle, strobe dropped at the taking edge
  task automatic wr_reg(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk); addr <= a; wdata <= d; wr <= 1'b1;
    @(posedge clk); wr <= 1'b0; #1;
  endtask : wr_reg
  // one read cycle, data taken in the following cycle
  task automatic rd_reg(input logic [7:0] a, output logic [15:0] d);
    @(posedge clk); addr <= a; rd <= 1'b1;
    @(posedge clk); rd <= 1'b0; #1 d = rdata;
  endtask : rd_reg
  // key bytes and lock write as three back-to-back writes
  task automatic key_lock(input logic l);
    @(posedge clk); addr <= rpm_pkg::ADDR_OSC_CTRL; wdata <= 16'h0046; wr <= 1'b1;
    @(posedge clk); wdata <= 16'h0057;
    @(posedge clk); wdata <= {9'h000, l, 6'h00};
    @(posedge clk); wr <= 1'b0; #1;
  endtask : key_lock
  // reset held four cycles
  task automatic do_reset();
    @(posedge clk); rst_n <= 1'b0;
    repeat (4) @(posedge clk);
    rst_n <= 1'b1; #1;
  endtask : do_reset
  // codes that the output table maps to a peripheral
  function automatic logic code_used(input logic [4:0] c);
    return (c >= 5'h01 && c <= 5'h0c) || (c >= 5'h12 && c <= 5'h16) || c == 5'h1d || c == 5'h1e;
  endfunction : code_used
  // verdict and end of run
  task automatic close_out();
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : close_out
  // watchdog against a hang
  initial begin
    repeat (20000) @(posedge clk);
    n_fail++;
    close_out();
  end
  // main sequence
  initial begin
    repeat (4) @(posedge clk);
    rst_n <= 1'b1; #1;
    // reset state
    rd_reg(8'h40, v); chk("out sel reset", v, 32'h0);
    rd_reg(8'h10, v); chk("in sel reset", v, 32'h1f1f);
    chk("lock reset", lock, 32'h0);
    chk("oe reset", oe, 32'h0);
    chk("in tied low", pin_in_sel, 32'h0);
    rd_reg(8'h20, v); chk("unmapped read", v, 32'h0);
    rd_reg(8'h01, v); chk("status idle", v, 32'h0);
    $display("test reset done");
    // every output code on pins 0 and 1, both fields of the first output word
    for (int c = 0; c < 32; c++) begin
      wr_reg(8'h40, {3'h0, c[4:0], 3'h0, c[4:0]});
      rd_reg(8'h40, v); chk("out word", v, {3'h0, c[4:0], 3'h0, c[4:0]});
      chk("pin0 oe", oe[0], code_used(c[4:0]));
      chk("pin0 val", pin_o[0], code_used(c[4:0]) ? func[c] : port[0]);
      chk("pin1 oe", oe[1], code_used(c[4:0]));
      chk("pin1 val", pin_o[1], code_used(c[4:0]) ? func[c] : port[1]);
    end
    $display("test output codes done");
    // one source on two pins, one pin into two inputs
    wr_reg(8'h40, 16'h0303);
    chk("fan out", {pin_o[1:0], oe[1:0]}, {func[3], func[3], 2'b11});
    wr_reg(8'h10, 16'h0202);
    chk("fan in", pin_in_sel[1:0], {pin_lvl[2], pin_lvl[2]});
    // absent pins 12 and 26, present pin 25 on 44 pins and pin 15 on 28 pins
    wr_reg(8'h46, 16'h0003); wr_reg(8'h4c, 16'h0300); wr_reg(8'h4d, 16'h0003);
    wr_reg(8'h47, 16'h0303);
    chk("variant pins", {oe[26], oe[25], oe[12]}, 32'h2);
    chk("variant 28", {oe28[26], oe28[25], oe28[15], oe28[12]}, 32'h2);
    $display("test mapping done");
    // lock with unlimited sessions
    key_lock(1'b1); chk("lock set", lock, 32'h1);
    rd_reg(8'h00, v); chk("lock bit", v[6], 32'h1);
    wr_reg(8'h40, 16'h0101); rd_reg(8'h40, v); chk("locked out", v, 32'h0303);
    wr_reg(8'h10, 16'h0505); rd_reg(8'h10, v); chk("locked in", v, 32'h0202);
    wr_reg(8'h00, 16'h0046); wr_reg(8'h41, 16'h0000);
    wr_reg(8'h00, 16'h0057); wr_reg(8'h00, 16'h0000);
    chk("broken key", lock, 32'h1);
    key_lock(1'b0); chk("unlocked", lock, 32'h0);
    wr_reg(8'h40, 16'h1e12); wr_reg(8'h41, 16'h1d00);
    rd_reg(8'h40, v); chk("session w1", v, 32'h1e12);
    rd_reg(8'h41, v); chk("session w2", v, 32'h1d00);
    key_lock(1'b1); key_lock(1'b0); chk("second session", lock, 32'h0);
    chk("no mismatch", mism, 32'h0);
    $display("test lock done");
    // single session fuse
    @(posedge clk); fuse <= 1'b1;
    do_reset();
    key_lock(1'b1); chk("fuse lock", lock, 32'h1);
    key_lock(1'b0); chk("fuse hold", lock, 32'h1);
    wr_reg(8'h40, 16'h0101); rd_reg(8'h40, v); chk("fuse map", v, 32'h0);
    do_reset(); chk("reset clears", lock, 32'h0);
    chk("mismatch idle", mism, 32'h0);
    rd_reg(8'h01, v); chk("status fuse", v, 32'h2);
    $display("test fuse done");
    close_out();
  end
endmodule : rpm_pin_mux_tb
